//--- rtl/uec_ctrl.sv
// USB endpoint control and status registers with token answer logic.
// Assumes a same-clock serial engine and a classic Wishbone master.
`timescale 1ns/1ps

module uec_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input uec_pkg::uec_token_t token_i,
    input uec_pkg::uec_event_t event_i,
    output uec_pkg::uec_reply_t reply_o,
    output logic usb_enable_o,
    output logic suspend_o,
    output logic sys_reset_req_o,
    output logic irq_o
);
    import uec_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] func_addr;
        logic tx0f;
        logic rx0f;
        logic brst_flag;
        logic suspend;
        logic tx0ie;
        logic rx0ie;
        logic tx1f;
        logic eop_flag;
        logic resume_flag;
        logic tx1ie;
        logic eop_ie;
        logic [7:0] ctrl_ep;
        logic [7:0] shared_ep;
        logic ack;
        logic [7:0] rdat;
        uec_reply_t reply;
        logic reset_req;
        logic irq;
    } uec_state_t;

    uec_state_t st;
    uec_state_t next_st;

    function automatic logic hits(input logic [7:0] adr,
                                  input logic [7:0] idx);
        hits = (adr[7:2] == idx[5:0]) && (adr[1:0] == 2'h0);
    endfunction

    logic bus_req;
    logic wr_now;
    logic tok_match;

    assign bus_req = wb_cyc_i && wb_stb_i;
    // A write lands at the edge where the master sees ack
    assign wr_now = bus_req && st.ack && wb_we_i && wb_sel_i[0];
    assign tok_match = token_i.valid && st.func_addr[FA_ENABLE]
                       && (token_i.addr == st.func_addr[6:0]);

    always_comb begin
        next_st = st;
        next_st.reset_req = 1'b0;
        next_st.reply = '0;

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (wr_now && hits(wb_adr_i, IDX_FUNC_ADDR)) begin
            next_st.func_addr = wb_dat_i[7:0];
        end
        if (wr_now && hits(wb_adr_i, IDX_FLAGS_ZERO)) begin
            next_st.suspend = wb_dat_i[F0_SUSP];
            next_st.tx0ie = wb_dat_i[F0_TXIE];
            next_st.rx0ie = wb_dat_i[F0_RXIE];
            if (wb_dat_i[F0_TXCLR]) begin
                next_st.tx0f = 1'b0;
            end
            if (wb_dat_i[F0_RXCLR]) begin
                next_st.rx0f = 1'b0;
            end
        end
        if (wr_now && hits(wb_adr_i, IDX_FLAGS_ONE)) begin
            next_st.tx1ie = wb_dat_i[F1_TXIE];
            next_st.eop_ie = wb_dat_i[F1_EOP_IE];
            if (wb_dat_i[F1_TXCLR]) begin
                next_st.tx1f = 1'b0;
            end
            if (wb_dat_i[F1_EOPCLR]) begin
                next_st.eop_flag = 1'b0;
            end
            if (wb_dat_i[F1_RESCLR]) begin
                next_st.resume_flag = 1'b0;
            end
        end
        if (wr_now && hits(wb_adr_i, IDX_CTRL_EP)) begin
            next_st.ctrl_ep = wb_dat_i[7:0];
        end
        if (wr_now && hits(wb_adr_i, IDX_SHARED_EP)) begin
            next_st.shared_ep = wb_dat_i[7:0];
        end

        // --------------------------------------------------------
        // Hardware events, placed after writes so a set wins
        // --------------------------------------------------------
        if (event_i.ctrl_tx_acked) begin
            next_st.tx0f = 1'b1;
        end
        if (event_i.ctrl_rx_acked) begin
            next_st.rx0f = 1'b1;
        end
        if (event_i.shared_tx_acked) begin
            next_st.tx1f = 1'b1;
        end
        if (event_i.eop_seen) begin
            next_st.eop_flag = 1'b1;
        end
        if (event_i.bus_activity && st.suspend) begin
            next_st.resume_flag = 1'b1;
        end

        // --------------------------------------------------------
        // Token answers
        // --------------------------------------------------------
        if (tok_match && token_i.ep == EP_CTRL) begin
            next_st.reply.valid = 1'b1;
            next_st.reply.ep = EP_CTRL;
            next_st.reply.data1 = st.ctrl_ep[CE_TOGGLE];
            next_st.reply.count = st.ctrl_ep[3:0];
            case (token_i.pid)
                PID_SETUP: begin
                    // SETUP is always taken and drops a forced stall
                    next_st.reply.ans = ANS_ACCEPT;
                    next_st.ctrl_ep[CE_STALL] = 1'b0;
                end
                PID_IN: begin
                    if (st.ctrl_ep[CE_STALL]) begin
                        next_st.reply.ans = ANS_STALL;
                    end else if (!st.ctrl_ep[CE_TXEN] || st.tx0f) begin
                        next_st.reply.ans = ANS_NAK;
                    end else begin
                        next_st.reply.ans = ANS_DATA;
                    end
                end
                PID_OUT: begin
                    if (st.ctrl_ep[CE_STALL]) begin
                        next_st.reply.ans = ANS_STALL;
                    end else if (!st.ctrl_ep[CE_RXEN] || st.rx0f) begin
                        next_st.reply.ans = ANS_NAK;
                    end else begin
                        next_st.reply.ans = ANS_ACCEPT;
                    end
                end
                default: begin
                    next_st.reply.valid = 1'b0;
                end
            endcase
        end else if (tok_match && token_i.pid == PID_IN
                     && (token_i.ep == EP_ONE || token_i.ep == EP_TWO)) begin
            next_st.reply.valid = 1'b1;
            next_st.reply.ep = token_i.ep;
            next_st.reply.data1 = st.shared_ep[SE_TOGGLE];
            next_st.reply.count = st.shared_ep[3:0];
            if (!st.shared_ep[SE_TXEN] || st.tx1f) begin
                next_st.reply.ans = ANS_NAK;
            end else begin
                next_st.reply.ans = ANS_DATA;
            end
        end

        // --------------------------------------------------------
        // Bus slave: one wait state, unmapped reads give zero
        // --------------------------------------------------------
        next_st.ack = bus_req && !st.ack;
        next_st.rdat = 8'h00;
        if (bus_req && !st.ack) begin
            if (hits(wb_adr_i, IDX_FUNC_ADDR)) begin
                next_st.rdat = st.func_addr;
            end else if (hits(wb_adr_i, IDX_FLAGS_ZERO)) begin
                next_st.rdat = {st.tx0f, st.rx0f, st.brst_flag, st.suspend,
                                st.tx0ie, st.rx0ie, 2'h0};
            end else if (hits(wb_adr_i, IDX_FLAGS_ONE)) begin
                next_st.rdat = {st.tx1f, st.eop_flag, st.resume_flag, 1'b0,
                                st.tx1ie, st.eop_ie, 2'h0};
            end else if (hits(wb_adr_i, IDX_CTRL_EP)) begin
                next_st.rdat = st.ctrl_ep;
            end else if (hits(wb_adr_i, IDX_SHARED_EP)) begin
                next_st.rdat = st.shared_ep;
            end
        end

        // Resume has no enable of its own, so it always interrupts
        next_st.irq = (st.tx0f && st.tx0ie)
                    || (st.rx0f && st.rx0ie)
                    || (st.eop_flag && st.eop_ie)
                    || (st.tx1f && st.tx1ie)
                    || st.resume_flag;

        // Bus reset clears the module like a system reset but sets
        // its own flag, which only rst_i may clear
        if (event_i.bus_reset_seen) begin
            next_st = '0;
            next_st.brst_flag = 1'b1;
            next_st.reset_req = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = {24'h000000, st.rdat};
    assign reply_o = st.reply;
    assign usb_enable_o = st.func_addr[FA_ENABLE];
    // The clock gate outside acts on this level
    assign suspend_o = st.suspend;
    assign sys_reset_req_o = st.reset_req;
    assign irq_o = st.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic ctrl_tok;
    logic no_brst;
    assign ctrl_tok = tok_match && token_i.ep == EP_CTRL;
    assign no_brst = !event_i.bus_reset_seen;

    property p_disabled_quiet;
        token_i.valid && !usb_enable_o |=> !reply_o.valid;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("token answered while disabled");

    property p_addr_filter;
        token_i.valid && token_i.addr != st.func_addr[6:0] |=> !reply_o.valid;
    endproperty
    a_addr_filter: assert property (p_addr_filter)
        else $error("token to foreign address answered");

    property p_tx0_sets;
        event_i.ctrl_tx_acked && no_brst |=> st.tx0f;
    endproperty
    a_tx0_sets: assert property (p_tx0_sets)
        else $error("transmit-done flag not set");

    property p_rx0_sets;
        event_i.ctrl_rx_acked && no_brst |=> st.rx0f;
    endproperty
    a_rx0_sets: assert property (p_rx0_sets)
        else $error("receive-done flag not set");

    property p_bus_reset;
        event_i.bus_reset_seen |=> st.brst_flag && sys_reset_req_o && !irq_o
            ##1 st.brst_flag;
    endproperty
    a_bus_reset: assert property (p_bus_reset)
        else $error("bus reset handling wrong");

    property p_resume;
        event_i.bus_activity && suspend_o && no_brst
            |=> st.resume_flag ##1 irq_o;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume flag or interrupt missing");

    property p_tx_clear;
        wr_now && hits(wb_adr_i, IDX_FLAGS_ZERO) && wb_dat_i[F0_TXCLR]
            && !event_i.ctrl_tx_acked && no_brst |=> !st.tx0f;
    endproperty
    a_tx_clear: assert property (p_tx_clear)
        else $error("transmit-done flag not cleared");

    property p_eop_clear;
        wr_now && hits(wb_adr_i, IDX_FLAGS_ONE) && wb_dat_i[F1_EOPCLR]
            && !event_i.eop_seen && no_brst |=> !st.eop_flag;
    endproperty
    a_eop_clear: assert property (p_eop_clear)
        else $error("end-of-packet flag not cleared");

    property p_irq_tx0;
        st.tx0f && st.tx0ie && no_brst |=> irq_o;
    endproperty
    a_irq_tx0: assert property (p_irq_tx0)
        else $error("transmit interrupt missing");

    property p_irq_eop;
        st.eop_flag && st.eop_ie && no_brst |=> irq_o;
    endproperty
    a_irq_eop: assert property (p_irq_eop)
        else $error("end-of-packet interrupt missing");

    property p_stall;
        ctrl_tok && token_i.pid != PID_SETUP && token_i.pid != PID_OTHER
            && st.ctrl_ep[CE_STALL] && no_brst |=> reply_o.ans == ANS_STALL;
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall not answered");

    property p_setup_unstall;
        ctrl_tok && token_i.pid == PID_SETUP && !wr_now && no_brst
            |=> !st.ctrl_ep[CE_STALL];
    endproperty
    a_setup_unstall: assert property (p_setup_unstall)
        else $error("setup left stall set");

    property p_in_nak;
        ctrl_tok && token_i.pid == PID_IN && !st.ctrl_ep[CE_STALL] && no_brst
            && (!st.ctrl_ep[CE_TXEN] || st.tx0f) |=> reply_o.ans == ANS_NAK;
    endproperty
    a_in_nak: assert property (p_in_nak)
        else $error("IN not refused");

    property p_out_nak;
        ctrl_tok && token_i.pid == PID_OUT && !st.ctrl_ep[CE_STALL] && no_brst
            && (!st.ctrl_ep[CE_RXEN] || st.rx0f) |=> reply_o.ans == ANS_NAK;
    endproperty
    a_out_nak: assert property (p_out_nak)
        else $error("OUT not refused");

    property p_shared_nak;
        tok_match && token_i.pid == PID_IN && st.tx1f && no_brst
            && (token_i.ep == EP_ONE || token_i.ep == EP_TWO)
            |=> reply_o.ans == ANS_NAK;
    endproperty
    a_shared_nak: assert property (p_shared_nak)
        else $error("shared IN not refused");

    property p_toggle_count;
        ctrl_tok && token_i.pid == PID_IN && no_brst |=>
            reply_o.data1 == $past(st.ctrl_ep[CE_TOGGLE])
            && reply_o.count == $past(st.ctrl_ep[3:0]);
    endproperty
    a_toggle_count: assert property (p_toggle_count)
        else $error("toggle or count wrong");

    c_data: cover property (reply_o.valid && reply_o.ans == ANS_DATA);
    c_stall: cover property (reply_o.ans == ANS_STALL);
    c_irq: cover property (!irq_o ##1 irq_o);
    c_brst: cover property (sys_reset_req_o);

endmodule

//--- rtl/uec_pkg.sv
// Package for the USB endpoint control and status block.
// Assumes a serial engine on the same clock that reports tokens and events.
package uec_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FUNC_ADDR = 8'h38;
    localparam logic [7:0] IDX_FLAGS_ZERO = 8'h39;
    localparam logic [7:0] IDX_FLAGS_ONE = 8'h3A;
    localparam logic [7:0] IDX_CTRL_EP = 8'h3B;
    localparam logic [7:0] IDX_SHARED_EP = 8'h3C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FA_ENABLE = 7;
    localparam int F0_TXF = 7;
    localparam int F0_RXF = 6;
    localparam int F0_BRST = 5;
    localparam int F0_SUSP = 4;
    localparam int F0_TXIE = 3;
    localparam int F0_RXIE = 2;
    localparam int F0_TXCLR = 1;
    localparam int F0_RXCLR = 0;
    localparam int F1_TXF = 7;
    localparam int F1_EOP = 6;
    localparam int F1_RESF = 5;
    localparam int F1_RESCLR = 4;
    localparam int F1_TXIE = 3;
    localparam int F1_EOP_IE = 2;
    localparam int F1_TXCLR = 1;
    localparam int F1_EOPCLR = 0;
    localparam int CE_TOGGLE = 7;
    localparam int CE_STALL = 6;
    localparam int CE_TXEN = 5;
    localparam int CE_RXEN = 4;
    localparam int SE_TOGGLE = 7;
    localparam int SE_TXEN = 5;

    // ------------------------------------------------------------
    // Reset values and endpoint numbers
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] EP_CTRL = 2'h0;
    localparam logic [1:0] EP_ONE = 2'h1;
    localparam logic [1:0] EP_TWO = 2'h2;

    typedef enum logic [1:0] {
        PID_OUT = 2'h0,
        PID_IN = 2'h1,
        PID_SETUP = 2'h2,
        PID_OTHER = 2'h3
    } uec_pid_t;

    typedef enum logic [2:0] {
        ANS_IGNORE = 3'h0,
        ANS_DATA = 3'h1,
        ANS_ACCEPT = 3'h2,
        ANS_NAK = 3'h3,
        ANS_STALL = 3'h4
    } uec_answer_t;

    typedef struct packed {
        logic valid;
        uec_pid_t pid;
        logic [6:0] addr;
        logic [1:0] ep;
    } uec_token_t;

    typedef struct packed {
        logic valid;
        uec_answer_t ans;
        logic [1:0] ep;
        logic data1;
        logic [3:0] count;
    } uec_reply_t;

    typedef struct packed {
        logic ctrl_tx_acked;
        logic ctrl_rx_acked;
        logic shared_tx_acked;
        logic eop_seen;
        logic bus_reset_seen;
        logic bus_activity;
    } uec_event_t;

endpackage

//--- dv/uec_host_model.sv
// Far-side model: issues tokens and bus events as the serial engine would.
// Assumes the controller samples both on the rising edge of clk_i.
`timescale 1ns/1ps

module uec_host_model (
    input wire logic clk_i,
    output uec_pkg::uec_token_t token_o,
    output uec_pkg::uec_event_t event_o
);
    import uec_pkg::*;

    initial begin
        token_o = '0;
        event_o = '0;
    end

    // ------------------------------------------------------------
    // Token and event drivers
    // ------------------------------------------------------------
    // Idle fields are inverted so a stale token cannot pass for a live one
    task automatic send_token(uec_pid_t pid, logic [6:0] a, logic [1:0] ep);
        @(posedge clk_i);
        token_o <= '{valid: 1'b1, pid: pid, addr: a, ep: ep};
        @(posedge clk_i);
        token_o <= '{valid: 1'b0, pid: uec_pid_t'(~pid), addr: ~a, ep: ~ep};
    endtask

    task automatic pulse_event(logic [5:0] m);
        @(posedge clk_i);
        event_o <= uec_event_t'(m);
        @(posedge clk_i);
        event_o <= '0;
    endtask
endmodule

//--- dv/uec_ctrl_tb.sv
// Self-checking bench for the endpoint control and status block.
// Assumes the host model beside it drives the token and event inputs.
`timescale 1ns/1ps

module uec_ctrl_tb;
    import uec_pkg::*;

    localparam logic [7:0] A_FA = {IDX_FUNC_ADDR[5:0], 2'h0};
    localparam logic [7:0] A_F0 = {IDX_FLAGS_ZERO[5:0], 2'h0};
    localparam logic [7:0] A_F1 = {IDX_FLAGS_ONE[5:0], 2'h0};
    localparam logic [7:0] A_CE = {IDX_CTRL_EP[5:0], 2'h0};
    localparam logic [7:0] A_SE = {IDX_SHARED_EP[5:0], 2'h0};
    localparam logic [6:0] ADR = 7'h2A;
    // Event masks, most significant field first
    localparam logic [5:0] EV_TX = 6'h20, EV_RX = 6'h10, EV_SH = 6'h08;
    localparam logic [5:0] EV_EOP = 6'h04, EV_RST = 6'h02, EV_ACT = 6'h01;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc, wb_stb, wb_we, ack, usb_en, susp, sreq, irq;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_q, dat_o;
    uec_token_t tok;
    uec_event_t ev;
    uec_reply_t reply;
    int fail_count = 0;
    int num_checks = 0;

    always #2.5 clk_i = ~clk_i;

    uec_host_model host (.clk_i(clk_i), .token_o(tok), .event_o(ev));

    uec_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .token_i(tok), .event_i(ev), .reply_o(reply),
        .usb_enable_o(usb_en), .suspend_o(susp),
        .sys_reset_req_o(sreq), .irq_o(irq));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] b(int p);
        return 8'h01 << p;
    endfunction

    task complete_run;
        $display("Checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wb(logic we, logic [7:0] a, logic [7:0] d, logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= {24'h000000, d};
        wb_sel <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            fail_count++;
            $display("Error wb_ack_o expected 1 seen %b", ack);
            complete_run();
        end
        wb_q = dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        // The write lands at this edge; callers look one edge later
        @(posedge clk_i);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask

    task automatic rc(logic [7:0] a, logic [7:0] e);
        wb(1'b0, a, 8'h00, 4'hF);
        chk("wb_dat_o", {24'h000000, e}, wb_q);
    endtask

    task automatic tk(uec_pid_t p, logic [6:0] a, logic [1:0] ep, logic v,
                      uec_answer_t ans, logic d1);
        host.send_token(p, a, ep);
        @(posedge clk_i);
        num_checks++;
        if (reply.valid !== v || (v && (reply.ans !== ans ||
                reply.data1 !== d1))) begin
            fail_count++;
            $display("Error reply_o expected %b %0d %b seen %b %0d %b",
                v, ans, d1, reply.valid, reply.ans, reply.data1);
        end
    endtask

    task automatic rst;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] al [5] = '{A_FA, A_F0, A_F1, A_CE, A_SE};
        foreach (al[i]) rc(al[i], REG_RESET);
        wb(1'b1, A_FA, 8'hFF, 4'hE);
        rc(A_FA, 8'h00);
        wr(A_SE, 8'hFF);
        rc(A_SE, 8'hFF);
        wr(A_SE, 8'h00);
        rc(8'h00, 8'h00);
        rc(A_FA + 8'h01, 8'h00);
    endtask

    task automatic t_disabled;
        wr(A_FA, {1'b0, ADR});
        wr(A_CE, b(CE_TXEN));
        tk(PID_IN, ADR, EP_CTRL, 1'b0, ANS_IGNORE, 1'b0);
        chk("usb_enable_o", 32'h0, {31'h0, usb_en});
        wr(A_FA, b(FA_ENABLE) | {1'b0, ADR});
        chk("usb_enable_o", 32'h1, {31'h0, usb_en});
        tk(PID_IN, ADR ^ 7'h01, EP_CTRL, 1'b0, ANS_IGNORE, 1'b0);
        tk(PID_IN, ADR, EP_CTRL, 1'b1, ANS_DATA, 1'b0);
        tk(PID_OTHER, ADR, EP_CTRL, 1'b0, ANS_IGNORE, 1'b0);
    endtask

    task automatic t_ep0_in;
        wr(A_CE, 8'h00);
        tk(PID_IN, ADR, EP_CTRL, 1'b1, ANS_NAK, 1'b0);
        wr(A_CE, b(CE_TOGGLE) | b(CE_TXEN) | 8'h0F);
        tk(PID_IN, ADR, EP_CTRL, 1'b1, ANS_DATA, 1'b1);
        chk("reply_o.count", 32'hF, {28'h0, reply.count});
        wr(A_F0, b(F0_TXIE));
        host.pulse_event(EV_TX);
        rc(A_F0, b(F0_TXF) | b(F0_TXIE));
        chk("irq_o", 32'h1, {31'h0, irq});
        tk(PID_IN, ADR, EP_CTRL, 1'b1, ANS_NAK, 1'b1);
        wr(A_F0, b(F0_TXIE));
        rc(A_F0, b(F0_TXF) | b(F0_TXIE));
        wr(A_F0, b(F0_TXIE) | b(F0_TXCLR));
        rc(A_F0, b(F0_TXIE));
        chk("irq_o", 32'h0, {31'h0, irq});
        tk(PID_IN, ADR, EP_CTRL, 1'b1, ANS_DATA, 1'b1);
        rc(A_CE, b(CE_TOGGLE) | b(CE_TXEN) | 8'h0F);
        wr(A_F0, 8'h00);
    endtask

    task automatic t_ep0_out;
        wr(A_CE, 8'h00);
        tk(PID_OUT, ADR, EP_CTRL, 1'b1, ANS_NAK, 1'b0);
        wr(A_CE, b(CE_RXEN));
        tk(PID_OUT, ADR, EP_CTRL, 1'b1, ANS_ACCEPT, 1'b0);
        host.pulse_event(EV_RX);
        rc(A_F0, b(F0_RXF));
        chk("irq_o", 32'h0, {31'h0, irq});
        wr(A_F0, b(F0_RXIE));
        rc(A_F0, b(F0_RXF) | b(F0_RXIE));
        chk("irq_o", 32'h1, {31'h0, irq});
        tk(PID_OUT, ADR, EP_CTRL, 1'b1, ANS_NAK, 1'b0);
        wr(A_F0, b(F0_RXIE) | b(F0_RXCLR));
        rc(A_F0, b(F0_RXIE));
        wr(A_F0, 8'h00);
    endtask

    task automatic t_stall;
        wr(A_CE, b(CE_STALL) | b(CE_TXEN) | b(CE_RXEN));
        tk(PID_IN, ADR, EP_CTRL, 1'b1, ANS_STALL, 1'b0);
        tk(PID_OUT, ADR, EP_CTRL, 1'b1, ANS_STALL, 1'b0);
        tk(PID_SETUP, ADR, EP_CTRL, 1'b1, ANS_ACCEPT, 1'b0);
        rc(A_CE, b(CE_TXEN) | b(CE_RXEN));
        tk(PID_IN, ADR, EP_CTRL, 1'b1, ANS_DATA, 1'b0);
    endtask

    task automatic t_shared;
        wr(A_SE, b(SE_TOGGLE) | b(SE_TXEN));
        wr(A_F1, b(F1_TXIE));
        tk(PID_IN, ADR, EP_ONE, 1'b1, ANS_DATA, 1'b1);
        chk("reply_o.ep", {30'h0, EP_ONE}, {30'h0, reply.ep});
        tk(PID_OUT, ADR, EP_ONE, 1'b0, ANS_IGNORE, 1'b0);
        host.pulse_event(EV_SH);
        rc(A_F1, b(F1_TXF) | b(F1_TXIE));
        chk("irq_o", 32'h1, {31'h0, irq});
        tk(PID_IN, ADR, EP_TWO, 1'b1, ANS_NAK, 1'b1);
        wr(A_F1, b(F1_TXIE) | b(F1_TXCLR));
        rc(A_F1, b(F1_TXIE));
        wr(A_F1, 8'h00);
        wr(A_SE, b(SE_TOGGLE));
        tk(PID_IN, ADR, EP_TWO, 1'b1, ANS_NAK, 1'b1);
    endtask

    task automatic t_eop_resume;
        wr(A_F1, b(F1_EOP_IE));
        host.pulse_event(EV_EOP);
        rc(A_F1, b(F1_EOP) | b(F1_EOP_IE));
        chk("irq_o", 32'h1, {31'h0, irq});
        wr(A_F1, b(F1_EOP_IE));
        rc(A_F1, b(F1_EOP) | b(F1_EOP_IE));
        wr(A_F1, b(F1_EOP_IE) | b(F1_EOPCLR));
        rc(A_F1, b(F1_EOP_IE));
        host.pulse_event(EV_ACT);
        rc(A_F1, b(F1_EOP_IE));
        wr(A_F0, b(F0_SUSP));
        chk("suspend_o", 32'h1, {31'h0, susp});
        host.pulse_event(EV_ACT);
        rc(A_F1, b(F1_RESF) | b(F1_EOP_IE));
        chk("irq_o", 32'h1, {31'h0, irq});
        wr(A_F0, 8'h00);
        chk("suspend_o", 32'h0, {31'h0, susp});
        wr(A_F1, b(F1_RESCLR));
        rc(A_F1, 8'h00);
        chk("irq_o", 32'h0, {31'h0, irq});
    endtask

    task automatic t_bus_reset;
        int n;
        n = 0;
        host.pulse_event(EV_RST);
        repeat (4) begin
            if (sreq === 1'b1) n++;
            @(posedge clk_i);
        end
        chk("sys_reset_req_o", 32'h1, n);
        rc(A_F0, b(F0_BRST));
        rc(A_FA, 8'h00);
        rst();
        rc(A_F0, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
        rst();
        t_reset();
        t_disabled();
        t_ep0_in();
        t_ep0_out();
        t_stall();
        t_shared();
        t_eop_resume();
        t_bus_reset();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("Error watchdog expected done seen hang");
        complete_run();
    end
endmodule
